// ### rtl/charger_control_temp_config_regs.sv
// charger configuration bank: input FETs, protection, thermal, derating
// How it works
// - each absent input FET locks its own driver off
// - frequency bit loads from strap at power-up
// - indicator disable bit stops driving status pin
// - short disable bit skips system-short hiccup
// - undervoltage disable bit skips reverse hiccup
// - forced detect accepted only above minimum
// - detection halts, measures, updates, self-clears
// - input overcurrent protection resets enabled
// - ship switch absent holds related bits zero
// - discharge sense bit enables current sensing
// - discharge limit codes 3A/4A/5A/off
// - internal input limit bit enables regulation
// - external limit bit honours limit pin
// - battery overcurrent bit enables protection
// - thermal regulation codes 60 to 120 C
// - thermal shutdown codes 150/130/120/85 C
// - main input pull-down bit connects resistor
// - aux pull-down bits connect their resistors
// - warm voltage code lowers or suspends
// - warm current code scales or suspends
// - cool current code scales or suspends
// - watchdog restores marked fields, register reset all but the FET, freq and fitted bits
`timescale 1ns/100ps
`default_nettype none
module charger_control_temp_config_regs
   import chgcfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port behind the host serial interface
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rd_data,
   // restore events, same clock
   input wire logic watchdog_expired,
   input wire logic reg_reset,
   // pins and comparators, asynchronous
   input wire logic prog_strap_pin,
   input wire logic fet1_absent_pin,
   input wire logic fet2_absent_pin,
   input wire logic vbat_above_min_system_voltage,
   // charger core requests, same clock
   input wire logic adc_done,
   input wire logic stat_drive_req,
   input wire logic force_ship_off_req,
   input wire logic [1:0] ship_action_req,
   // input FETs and converter
   output logic input_fet1_driver_on,
   output logic input_fet2_driver_on,
   output logic switching_freq_sel,
   output logic converter_halt,
   output logic vbus_measure_req,
   output logic input_limit_update,
   // status pin, open drain
   output logic stat_pin_o,
   output logic stat_pin_oe_b,
   // protection
   output logic sys_short_hiccup_on,
   output logic reverse_undervolt_hiccup_on,
   output logic input_overcurrent_protect_on,
   output logic battery_overcurrent_on,
   output logic force_ship_switch_off,
   output logic [1:0] ship_switch_action,
   // current regulation
   output logic discharge_sense_on,
   output logic discharge_limit_on,
   output logic [12:0] discharge_limit_ma,
   output logic internal_input_limit_on,
   output logic external_input_limit_on,
   // thermal and pull-downs
   output logic [7:0] thermal_regulation_c,
   output logic [7:0] thermal_shutdown_c,
   output logic main_input_pulldown_on,
   output logic aux_input1_pulldown_on,
   output logic aux_input2_pulldown_on,
   // temperature derating
   output logic warm_charge_suspend,
   output logic [9:0] warm_vreg_drop_mv,
   output logic [1:0] warm_charge_current_sel,
   output logic [1:0] cool_charge_current_sel
);

   // ==========================================================
   // pin synchronisers and power-up capture
   logic [3:0] pins_s;
   logic strap_s;
   logic fet1_abs_s;
   logic fet2_abs_s;
   logic vbat_ok_s;
   logic [1:0] cap_cnt_ff;
   logic cap_done_ff;
   logic cap_pulse;
   logic [1:0] fet_abs_ff;
   logic [1:0] fet_lock;

   pin_sync #(.W(4)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({vbat_above_min_system_voltage, fet2_absent_pin, fet1_absent_pin,
          prog_strap_pin}),
      .q(pins_s)
   );
   assign {vbat_ok_s, fet2_abs_s, fet1_abs_s, strap_s} = pins_s;

   // wait for the synchroniser to fill before trusting the straps
   assign cap_pulse = !cap_done_ff && (cap_cnt_ff == CAP_WAIT);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_cnt_ff <= 2'h0;
         cap_done_ff <= 1'b0;
      end else if (!cap_done_ff) begin
         cap_cnt_ff <= cap_cnt_ff + 2'h1;
         cap_done_ff <= cap_pulse;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fet_abs_ff <= 2'h0;
      end else if (cap_pulse) begin
         fet_abs_ff <= {fet2_abs_s, fet1_abs_s};
      end
   end

   // drivers stay locked until the presence check has been made
   assign fet_lock = fet_abs_ff | {2{!cap_done_ff}};

   // ==========================================================
   // register array
   logic [7:0] regs_ff [NREG];
   logic [7:0] base_nxt [NREG];
   logic [7:0] nxt_regs [NREG];
   logic [NREG-1:0] hit;
   logic det_done;
   logic fdet_wr1;

   for (genvar i = 0; i < NREG; i++) begin : g_reg
      assign hit[i] = reg_wr && (reg_addr == REG_OFS[i]);
      always_comb begin
         base_nxt[i] = upd(regs_ff[i], hit[i], reg_wdata, WR_MASK[i],
            watchdog_expired, reg_reset, WD_MASK[i], RR_MASK[i],
            RST_VAL[i]);
      end
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            regs_ff[i] <= RST_VAL[i];
         end else begin
            regs_ff[i] <= nxt_regs[i];
         end
      end
   end

   assign fdet_wr1 = hit[IX_C4] && reg_wdata[B_FDET];

   always_comb begin
      for (int k = 0; k < NREG; k++) begin
         nxt_regs[k] = base_nxt[k];
      end
      nxt_regs[IX_C4][B_FET1] = base_nxt[IX_C4][B_FET1] && !fet_lock[0];
      nxt_regs[IX_C4][B_FET2] = base_nxt[IX_C4][B_FET2] && !fet_lock[1];
      if (cap_pulse) begin
         nxt_regs[IX_C4][B_FREQ] = strap_s;
      end
      if (fdet_wr1 && !vbat_ok_s && !reg_reset) begin
         nxt_regs[IX_C4][B_FDET] = regs_ff[IX_C4][B_FDET];
      end
      // a fresh accepted write of 1 wins over the self-clear
      if (det_done && !(fdet_wr1 && vbat_ok_s)) begin
         nxt_regs[IX_C4][B_FDET] = 1'b0;
      end
      if (!nxt_regs[IX_C5][B_FITTED]) begin
         nxt_regs[IX_C5][B_BATOC] = 1'b0;
      end
   end

   // ==========================================================
   // forced detection
   detect_seq u_det (
      .clk(clk),
      .rst_b(rst_b),
      .start(regs_ff[IX_C4][B_FDET]),
      .adc_done(adc_done),
      .done(det_done),
      .converter_halt(converter_halt),
      .vbus_measure_req(vbus_measure_req),
      .input_limit_update(input_limit_update)
   );

   // ==========================================================
   // read port, one cycle latency
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h0;
      for (int k = 0; k < NREG; k++) begin
         if (reg_addr == REG_OFS[k]) begin
            rd_mux = regs_ff[k] & WR_MASK[k];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rd_data <= 8'h0;
      end else begin
         reg_rd_data <= rd_mux;
      end
   end

   // ==========================================================
   // field outputs, one cycle behind the register
   logic [7:0] c4;
   logic [7:0] c5;
   logic [7:0] tmp;
   logic [7:0] ntc;
   logic stat_en;

   assign c4 = regs_ff[IX_C4];
   assign c5 = regs_ff[IX_C5];
   assign tmp = regs_ff[IX_TMP];
   assign ntc = regs_ff[IX_NTC];
   assign stat_en = !c4[B_STAT_OFF];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         input_fet1_driver_on <= 1'b0;
         input_fet2_driver_on <= 1'b0;
         switching_freq_sel <= 1'b0;
         stat_pin_o <= 1'b1;
         stat_pin_oe_b <= 1'b1;
      end else begin
         input_fet1_driver_on <= c4[B_FET1] && !fet_lock[0];
         input_fet2_driver_on <= c4[B_FET2] && !fet_lock[1];
         switching_freq_sel <= c4[B_FREQ];
         // open drain: drive low only while enabled and requested
         stat_pin_o <= 1'b0;
         stat_pin_oe_b <= !(stat_en && stat_drive_req);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_short_hiccup_on <= 1'b1;
         reverse_undervolt_hiccup_on <= 1'b1;
         input_overcurrent_protect_on <= 1'b1;
         battery_overcurrent_on <= 1'b0;
         force_ship_switch_off <= 1'b0;
         ship_switch_action <= 2'h0;
      end else begin
         sys_short_hiccup_on <= !c4[B_SHORT_OFF];
         reverse_undervolt_hiccup_on <= !c4[B_UVP_OFF];
         input_overcurrent_protect_on <= c4[B_IOCP];
         battery_overcurrent_on <= c5[B_BATOC] && c5[B_FITTED];
         force_ship_switch_off <= force_ship_off_req && c5[B_FITTED];
         ship_switch_action <= ship_action_req & {2{c5[B_FITTED]}};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         discharge_sense_on <= 1'b0;
         discharge_limit_on <= 1'b1;
         discharge_limit_ma <= DLIM_MA[RST_VAL[IX_C5][B_DLIM +: 2]];
         internal_input_limit_on <= 1'b1;
         external_input_limit_on <= 1'b1;
      end else begin
         discharge_sense_on <= c5[B_SENSE];
         discharge_limit_on <= c5[B_DLIM +: 2] != DLIM_OFF;
         discharge_limit_ma <= DLIM_MA[c5[B_DLIM +: 2]];
         internal_input_limit_on <= c5[B_IINT];
         external_input_limit_on <= c5[B_IEXT];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         thermal_regulation_c <= THERMAL_REGULATION_THRESHOLD_C[RST_VAL[IX_TMP][B_THERMAL_REGULATION_THRESHOLD +: 2]];
         thermal_shutdown_c <= THERMAL_SHUTDOWN_THRESHOLD_C[RST_VAL[IX_TMP][B_THERMAL_SHUTDOWN_THRESHOLD +: 2]];
         main_input_pulldown_on <= 1'b0;
         aux_input1_pulldown_on <= 1'b0;
         aux_input2_pulldown_on <= 1'b0;
      end else begin
         thermal_regulation_c <= THERMAL_REGULATION_THRESHOLD_C[tmp[B_THERMAL_REGULATION_THRESHOLD +: 2]];
         thermal_shutdown_c <= THERMAL_SHUTDOWN_THRESHOLD_C[tmp[B_THERMAL_SHUTDOWN_THRESHOLD +: 2]];
         main_input_pulldown_on <= tmp[B_VBUS_PD];
         aux_input1_pulldown_on <= tmp[B_VAC1_PD];
         aux_input2_pulldown_on <= tmp[B_VAC2_PD];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warm_charge_suspend <= 1'b0;
         warm_vreg_drop_mv <= VSET_DROP_MV[RST_VAL[IX_NTC][B_VSET +: 3]];
         warm_charge_current_sel <= RST_VAL[IX_NTC][B_ISETH +: 2];
         cool_charge_current_sel <= RST_VAL[IX_NTC][B_ISETC +: 2];
      end else begin
         warm_charge_suspend <= ntc[B_VSET +: 3] == VSET_SUSPEND;
         warm_vreg_drop_mv <= VSET_DROP_MV[ntc[B_VSET +: 3]];
         warm_charge_current_sel <= ntc[B_ISETH +: 2];
         cool_charge_current_sel <= ntc[B_ISETC +: 2];
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_det_start;
      $rose(regs_ff[IX_C4][B_FDET]);
   endsequence
   sequence s_det_halt;
      ##[1:3] converter_halt;
   endsequence

   property p_fet_lock;
      cap_done_ff && fet_abs_ff[0] |-> !regs_ff[IX_C4][B_FET1]
         ##1 !input_fet1_driver_on;
   endproperty
   a_fet_lock: assert property (p_fet_lock) else $error("fet1 not locked");

   property p_freq_strap;
      cap_pulse |=> regs_ff[IX_C4][B_FREQ] == $past(strap_s)
         ##1 switching_freq_sel == $past(strap_s, 2);
   endproperty
   a_freq_strap: assert property (p_freq_strap) else $error("strap lost");

   property p_stat_off;
      c4[B_STAT_OFF] |=> stat_pin_oe_b;
   endproperty
   a_stat_off: assert property (p_stat_off) else $error("stat driven");

   property p_short_off;
      c4[B_SHORT_OFF] != c4[B_UVP_OFF] |=>
         sys_short_hiccup_on != reverse_undervolt_hiccup_on;
   endproperty
   a_short_off: assert property (p_short_off) else $error("hiccup mix");

   property p_uvp_off;
      c4[B_UVP_OFF] |=> !reverse_undervolt_hiccup_on;
   endproperty
   a_uvp_off: assert property (p_uvp_off) else $error("uvp hiccup on");

   property p_fdet_reject;
      fdet_wr1 && !vbat_ok_s && !c4[B_FDET] && !reg_reset |=> !c4[B_FDET];
   endproperty
   a_fdet_reject: assert property (p_fdet_reject) else $error("fdet taken");

   property p_fdet_seq;
      s_det_start |-> s_det_halt;
   endproperty
   a_fdet_seq: assert property (p_fdet_seq) else $error("no halt");

   property p_fdet_clear;
      det_done && !fdet_wr1 |=> !c4[B_FDET];
   endproperty
   a_fdet_clear: assert property (p_fdet_clear) else $error("fdet stuck");

   property p_iocp_reset;
      reg_reset |=> c4[B_IOCP] ##1 input_overcurrent_protect_on;
   endproperty
   a_iocp_reset: assert property (p_iocp_reset) else $error("iocp off");

   property p_ship_lock;
      !c5[B_FITTED] |-> !c5[B_BATOC] ##1 !force_ship_switch_off;
   endproperty
   a_ship_lock: assert property (p_ship_lock) else $error("ship unlocked");

   property p_wd_keep;
      watchdog_expired && !reg_reset && !hit[IX_C5] |=>
         c5[B_IEXT] == $past(c5[B_IEXT]) && c5[B_DLIM +: 2] == RST_VAL[IX_C5][B_DLIM +: 2];
   endproperty
   a_wd_keep: assert property (p_wd_keep) else $error("watchdog restore");

   property p_thermal_regulation_threshold;
      ##1 thermal_regulation_c == THERMAL_REGULATION_THRESHOLD_C[$past(tmp[B_THERMAL_REGULATION_THRESHOLD +: 2])];
   endproperty
   a_thermal_regulation_threshold: assert property (p_thermal_regulation_threshold) else $error("thermal_regulation_threshold decode");

   property p_rsvd_read;
      reg_addr == OFS_RSVD |=> reg_rd_data == 8'h0;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("rsvd nonzero");

endmodule : charger_control_temp_config_regs
`default_nettype wire

// ### rtl/chgcfg_pkg.sv
// constants, tables and types shared by the charger configuration bank
package chgcfg_pkg;

   // ==========================================================
   // register map
   localparam int NREG = 4;
   localparam int IX_C4 = 0;
   localparam int IX_C5 = 1;
   localparam int IX_TMP = 2;
   localparam int IX_NTC = 3;
   localparam logic [7:0] OFS_RSVD = 8'h15;
   localparam logic [7:0] REG_OFS [NREG] = '{8'h13, 8'h14, 8'h16, 8'h17};
   // freq bit of the first register is 0 here; the strap replaces it
   localparam logic [7:0] RST_VAL [NREG] = '{8'h01, 8'h16, 8'hc0, 8'h7a};
   localparam logic [7:0] WR_MASK [NREG] = '{8'hff, 8'hbf, 8'hfe, 8'hfe};
   localparam logic [7:0] WD_MASK [NREG] = '{8'h10, 8'h3d, 8'hf0, 8'hfe};
   localparam logic [7:0] RR_MASK [NREG] = '{8'h1f, 8'h3f, 8'hfe, 8'hfe};

   // ==========================================================
   // field positions
   localparam int B_FET2 = 7;
   localparam int B_FET1 = 6;
   localparam int B_FREQ = 5;
   localparam int B_STAT_OFF = 4;
   localparam int B_SHORT_OFF = 3;
   localparam int B_UVP_OFF = 2;
   localparam int B_FDET = 1;
   localparam int B_IOCP = 0;
   localparam int B_FITTED = 7;
   localparam int B_SENSE = 5;
   localparam int B_DLIM = 3;
   localparam int B_IINT = 2;
   localparam int B_IEXT = 1;
   localparam int B_BATOC = 0;
   localparam int B_THERMAL_REGULATION_THRESHOLD = 6;
   localparam int B_THERMAL_SHUTDOWN_THRESHOLD = 4;
   localparam int B_VBUS_PD = 3;
   localparam int B_VAC1_PD = 2;
   localparam int B_VAC2_PD = 1;
   localparam int B_VSET = 5;
   localparam int B_ISETH = 3;
   localparam int B_ISETC = 1;

   // ==========================================================
   // code tables
   localparam logic [12:0] DLIM_MA [4] = '{13'hbb8, 13'hfa0, 13'h1388, 13'h0};
   localparam logic [1:0] DLIM_OFF = 2'h3;
   localparam logic [7:0] THERMAL_REGULATION_THRESHOLD_C [4] = '{8'h3c, 8'h50, 8'h64, 8'h78};
   localparam logic [7:0] THERMAL_SHUTDOWN_THRESHOLD_C [4] = '{8'h96, 8'h82, 8'h78, 8'h55};
   localparam logic [9:0] VSET_DROP_MV [8] =
      '{10'h0, 10'h320, 10'h258, 10'h190, 10'h12c, 10'hc8, 10'h64, 10'h0};
   localparam logic [2:0] VSET_SUSPEND = 3'h0;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETTLE_NS = 1000;
   localparam logic [1:0] CAP_WAIT = 2'h2;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_HALT = 2'b01,
      DS_MEAS = 2'b11,
      DS_UPD = 2'b10
   } det_state_t;

   // write, then register reset over watchdog restore
   function automatic logic [7:0] upd(input logic [7:0] cur, input logic hit,
         input logic [7:0] wd_data, input logic [7:0] wm, input logic wd,
         input logic rr, input logic [7:0] wdm, input logic [7:0] rrm,
         input logic [7:0] rst);
      logic [7:0] v;
      v = cur;
      if (hit) begin
         v = (cur & ~wm) | (wd_data & wm);
      end
      if (rr) begin
         v = (v & ~rrm) | (rst & rrm);
      end else if (wd) begin
         v = (v & ~wdm) | (rst & wdm);
      end
      return v;
   endfunction : upd

endpackage : chgcfg_pkg

// ### rtl/pin_sync.sv
// two-stage synchroniser for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule : pin_sync
`default_nettype wire

// ### rtl/detect_seq.sv
// sequencer for a forced input-voltage-limit detection
`timescale 1ns/100ps
`default_nettype none
module detect_seq
   import chgcfg_pkg::*;
#(
   parameter int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic start,
   input wire logic adc_done,
   output logic done,
   // converter side
   output logic converter_halt,
   output logic vbus_measure_req,
   output logic input_limit_update
);
   det_state_t state_ff;
   det_state_t nxt_state;
   logic [7:0] cnt_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DS_IDLE: if (start) nxt_state = DS_HALT;
         DS_HALT: if (cnt_ff == 8'(SETTLE_CYC - 1)) nxt_state = DS_MEAS;
         DS_MEAS: if (adc_done) nxt_state = DS_UPD;
         DS_UPD: nxt_state = DS_IDLE;
         default: nxt_state = DS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= DS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // settle time lets the input current decay before measuring
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 8'h0;
      end else if (state_ff == DS_HALT) begin
         cnt_ff <= cnt_ff + 8'h1;
      end else begin
         cnt_ff <= 8'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         converter_halt <= 1'b0;
         vbus_measure_req <= 1'b0;
         input_limit_update <= 1'b0;
      end else begin
         converter_halt <= (nxt_state == DS_HALT) || (nxt_state == DS_MEAS);
         vbus_measure_req <= nxt_state == DS_MEAS;
         input_limit_update <= nxt_state == DS_UPD;
      end
   end

   assign done = state_ff == DS_UPD;
endmodule : detect_seq
`default_nettype wire

// ### testbench/charger_control_temp_config_regs_test.sv
// self-checking bench for the charger configuration bank
`timescale 1ns/100ps
`default_nettype none
module charger_control_temp_config_regs_test;
   import chgcfg_pkg::*;
   // ==========================================================
   // stimulus and observation
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rd_data;
   logic reg_wr = 1'b0, watchdog_expired = 1'b0, reg_reset = 1'b0;
   logic prog_strap_pin = 1'b1, fet1_absent_pin = 1'b1, fet2_absent_pin = 1'b0;
   logic vbat_above_min_system_voltage = 1'b0, adc_done = 1'b0, stat_drive_req = 1'b1;
   logic force_ship_off_req = 1'b0;
   logic [1:0] ship_action_req = 2'h0, ship_switch_action;
   logic [1:0] warm_charge_current_sel, cool_charge_current_sel;
   logic input_fet1_driver_on, input_fet2_driver_on, switching_freq_sel, converter_halt;
   logic vbus_measure_req, input_limit_update, stat_pin_o, stat_pin_oe_b;
   logic sys_short_hiccup_on, reverse_undervolt_hiccup_on, input_overcurrent_protect_on;
   logic battery_overcurrent_on, force_ship_switch_off, discharge_sense_on, discharge_limit_on;
   logic internal_input_limit_on, external_input_limit_on, main_input_pulldown_on;
   logic aux_input1_pulldown_on, aux_input2_pulldown_on, warm_charge_suspend;
   logic [12:0] discharge_limit_ma;
   logic [7:0] thermal_regulation_c, thermal_shutdown_c;
   logic [9:0] warm_vreg_drop_mv;
   int failures = 0;
   int checks = 0;
   int seed = 32'h904a;
   int i, k;
   logic [7:0] m [NREG];
   logic [7:0] d;
   int ma_t [4] = '{3000, 4000, 5000, 0};
   int thermal_regulation_threshold_t [4] = '{60, 80, 100, 120};
   int tsh_t [4] = '{150, 130, 120, 85};
   int drop_t [8] = '{0, 800, 600, 400, 300, 200, 100, 0};

   always #20 clk = ~clk;

   charger_control_temp_config_regs i_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd_data, .watchdog_expired, .reg_reset, .prog_strap_pin, .fet1_absent_pin,
      .fet2_absent_pin, .vbat_above_min_system_voltage, .adc_done, .stat_drive_req,
      .force_ship_off_req, .ship_action_req, .input_fet1_driver_on, .input_fet2_driver_on,
      .switching_freq_sel, .converter_halt, .vbus_measure_req, .input_limit_update,
      .stat_pin_o, .stat_pin_oe_b, .sys_short_hiccup_on, .reverse_undervolt_hiccup_on,
      .input_overcurrent_protect_on, .battery_overcurrent_on, .force_ship_switch_off,
      .ship_switch_action, .discharge_sense_on, .discharge_limit_on, .discharge_limit_ma,
      .internal_input_limit_on, .external_input_limit_on, .thermal_regulation_c,
      .thermal_shutdown_c, .main_input_pulldown_on, .aux_input1_pulldown_on,
      .aux_input2_pulldown_on, .warm_charge_suspend, .warm_vreg_drop_mv,
      .warm_charge_current_sel, .cool_charge_current_sel);

   // ==========================================================
   // checking and model
   task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   function automatic int ix(input logic [7:0] a);
      for (int j = 0; j < NREG; j++) begin
         if (REG_OFS[j] == a) return j;
      end
      return -1;
   endfunction : ix

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int j;
      logic [7:0] o;
      j = ix(a);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk);
      #2;
      reg_wr = 1'b0;
      // idle edge, so a following strobe never rises in the step that lowered it
      @(posedge clk);
      #2;
      if (j >= 0) begin
         o = m[j];
         m[j] = (o & ~WR_MASK[j]) | (v & WR_MASK[j]);
         if (j == IX_C4) begin
            m[j][6] = m[j][6] & !fet1_absent_pin;
            if (!vbat_above_min_system_voltage) m[j][1] = o[1];
         end
         if (j == IX_C5 && !m[j][7]) m[j][0] = 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int j;
      j = ix(a);
      reg_addr = a;
      @(posedge clk);
      #2;
      chk($sformatf("reg %h", a), reg_rd_data, (j >= 0) ? m[j] : 8'h00);
   endtask : rd

   // restore pulse: watchdog when w is set, else register reset
   task automatic rs(input logic w);
      watchdog_expired = w;
      reg_reset = !w;
      @(posedge clk);
      #2;
      watchdog_expired = 1'b0;
      reg_reset = 1'b0;
      for (int j = 0; j < NREG; j++) begin
         m[j] = w ? (m[j] & ~WD_MASK[j]) | (RST_VAL[j] & WD_MASK[j])
                  : (m[j] & ~RR_MASK[j]) | (RST_VAL[j] & RR_MASK[j]);
      end
   endtask : rs

   task automatic rd_all();
      for (int j = 0; j < 5; j++) rd(8'h13 + 8'(j));
   endtask : rd_all

   task automatic co();
      logic [7:0] a, b, c, e;
      a = m[IX_C4];
      b = m[IX_C5];
      c = m[IX_TMP];
      e = m[IX_NTC];
      chk("fet2", input_fet2_driver_on, a[7]);
      chk("fet1", input_fet1_driver_on, a[6]);
      chk("freq", switching_freq_sel, a[5]);
      chk("stat_o", stat_pin_o, 1'b0);
      chk("stat_oe", stat_pin_oe_b, !(stat_drive_req && !a[4]));
      chk("short", sys_short_hiccup_on, !a[3]);
      chk("uvp", reverse_undervolt_hiccup_on, !a[2]);
      chk("iocp", input_overcurrent_protect_on, a[0]);
      chk("shipoff", force_ship_switch_off, b[7] & force_ship_off_req);
      chk("shipact", ship_switch_action, b[7] ? ship_action_req : 2'h0);
      chk("sense", discharge_sense_on, b[5]);
      chk("limon", discharge_limit_on, b[4:3] != 2'h3);
      chk("lim", discharge_limit_ma, 13'(ma_t[b[4:3]]));
      chk("iint", internal_input_limit_on, b[2]);
      chk("iext", external_input_limit_on, b[1]);
      chk("batoc", battery_overcurrent_on, b[0]);
      chk("thermal_regulation_threshold", thermal_regulation_c, 13'(thermal_regulation_threshold_t[c[7:6]]));
      chk("thermal_shutdown_threshold", thermal_shutdown_c, 13'(tsh_t[c[5:4]]));
      chk("pd", main_input_pulldown_on, c[3]);
      chk("pd1", aux_input1_pulldown_on, c[2]);
      chk("pd2", aux_input2_pulldown_on, c[1]);
      chk("susp", warm_charge_suspend, e[7:5] == 3'h0);
      chk("drop", warm_vreg_drop_mv, 13'(drop_t[e[7:5]]));
      chk("iseth", warm_charge_current_sel, e[4:3]);
      chk("isetc", cool_charge_current_sel, e[2:1]);
   endtask : co

   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      #2;
      rst_b = 1'b1;
      for (int j = 0; j < NREG; j++) m[j] = RST_VAL[j];
      m[IX_C4][5] = prog_strap_pin;
      // straps need the capture edge plus the synchroniser
      repeat (8) @(posedge clk);
      #2;
      rd_all();
      co();
      for (i = 0; i < 60; i++) begin
         stat_drive_req = 1'($random(seed));
         force_ship_off_req = 1'($random(seed));
         ship_action_req = 2'($random(seed));
         d = 8'($random(seed));
         k = i % 6;
         if (k == 0) d[1] = 1'b0;
         if (k == 1) begin
            wr(8'h14, {i[3], m[IX_C5][6:1], 1'b0});
            d[7] = m[IX_C5][7];
         end
         wr((k == 5) ? 8'h20 : 8'h13 + 8'(k), d);
         rd((k == 5) ? 8'h13 : 8'h13 + 8'(k));
         co();
      end
      rs(1'b1);
      rd_all();
      co();
      for (k = 0; k < 5; k++) wr(8'h13 + 8'(k), 8'($random(seed)) & 8'hfd);
      rs(1'b0);
      rd_all();
      co();
      wr(8'h13, m[IX_C4] | 8'h02);
      rd(8'h13);
      vbat_above_min_system_voltage = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      wr(8'h13, m[IX_C4] | 8'h02);
      for (k = 0; k < 5 && converter_halt !== 1'b1; k++) begin
         @(posedge clk);
         #2;
      end
      chk("halt", converter_halt, 1'b1);
      for (k = 0; k < 60 && vbus_measure_req !== 1'b1; k++) begin
         @(posedge clk);
         #2;
      end
      chk("meas", vbus_measure_req, 1'b1);
      adc_done = 1'b1;
      @(posedge clk);
      #2;
      adc_done = 1'b0;
      chk("upd", input_limit_update, 1'b1);
      chk("halt_end", converter_halt, 1'b0);
      // the bit clears one edge after the update pulse
      @(posedge clk);
      #2;
      m[IX_C4][1] = 1'b0;
      rd(8'h13);
      report_and_stop();
   end

   // hang guard: the whole sequence needs well under 2000 cycles
   initial begin
      #(40 * 5000);
      failures++;
      report_and_stop();
   end
endmodule : charger_control_temp_config_regs_test
`default_nettype wire
